// File: common/crc_pkg.sv
package crc_pkg;

    // serial link timing at the 40 ns reference clock
    localparam int CLK_PERIOD_NS   = 40;
    localparam int CP_LOW_MIN_NS   = 35;
    localparam int CP_LOW_MIN_CYC  = (CP_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_PULSE_NS   = 35;
    localparam int INIT_PULSE_CYC  = (INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CYC_DEF    = 4;
    localparam int INIT_CYC_DEF    = 4;

    // feedback taps, leading term dropped, left aligned to the register top
    localparam logic [15:0] TAPS_CRC16     = 16'h8005;
    localparam logic [15:0] TAPS_CRC16_REV = 16'h4003;
    localparam logic [15:0] TAPS_POLY16_A  = 16'ha097;
    localparam logic [15:0] TAPS_CRC12     = 16'h80f0;
    localparam logic [15:0] TAPS_POLY8_A   = 16'hb300;
    localparam logic [15:0] TAPS_LRC8      = 16'h0100;
    localparam logic [15:0] TAPS_CCITT     = 16'h1021;
    localparam logic [15:0] TAPS_CCITT_REV = 16'h0811;

    // preset patterns by polynomial degree
    localparam logic [15:0] PRESET_DEG16 = 16'hffff;
    localparam logic [15:0] PRESET_DEG12 = 16'hfff0;
    localparam logic [15:0] PRESET_DEG8  = 16'hff00;

    // select codes
    localparam logic [2:0] SEL_CRC16     = 3'h0;
    localparam logic [2:0] SEL_CRC16_REV = 3'h1;
    localparam logic [2:0] SEL_POLY16_A  = 3'h2;
    localparam logic [2:0] SEL_CRC12     = 3'h3;
    localparam logic [2:0] SEL_POLY8_A   = 3'h4;
    localparam logic [2:0] SEL_LRC8      = 3'h5;
    localparam logic [2:0] SEL_CCITT     = 3'h6;
    localparam logic [2:0] SEL_CCITT_REV = 3'h7;

    // controller registers (byte addresses)
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_DATA   = 12'h004;
    localparam logic [11:0] ADDR_CMD    = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam logic [11:0] ADDR_RESULT = 12'h010;

    localparam int CMD_OP_LSB    = 0;
    localparam int CMD_CNT_LSB   = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_Q_BIT    = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    localparam logic [1:0] OP_CLEAR  = 2'h0;
    localparam logic [1:0] OP_PRESET = 2'h1;
    localparam logic [1:0] OP_DATA   = 2'h2;
    localparam logic [1:0] OP_CHECK  = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_HIGH, ST_LOW} host_state_t;

endpackage

// File: common/crc_link_if.sv
`timescale 1ns/1ps
interface crc_link_if;
    logic       cp;
    logic       d;
    logic       check_word_enable;
    logic [2:0] poly_select;
    logic       preset_n;
    logic       master_reset;
    logic       q;
    logic       fault_flag;

    modport device (
        input  cp, d, check_word_enable, poly_select, preset_n, master_reset,
        output q, fault_flag
    );
    modport host (
        output cp, d, check_word_enable, poly_select, preset_n, master_reset,
        input  q, fault_flag
    );
endinterface

// File: verilog/crc_poly_decode.sv
`timescale 1ns/1ps
module crc_poly_decode
    import crc_pkg::*;
(
    // select code
    input  wire logic [2:0]  i_poly_select,
    // decoded taps and preset pattern
    output logic      [15:0] o_taps,
    output logic      [15:0] o_preset_mask
);

    always_comb begin
        o_taps        = TAPS_CRC16;
        o_preset_mask = PRESET_DEG16;
        unique case (i_poly_select)
            SEL_CRC16:     o_taps = TAPS_CRC16;
            SEL_CRC16_REV: o_taps = TAPS_CRC16_REV;
            SEL_POLY16_A:  o_taps = TAPS_POLY16_A;
            SEL_CRC12: begin
                o_taps        = TAPS_CRC12;
                o_preset_mask = PRESET_DEG12;
            end
            SEL_POLY8_A: begin
                o_taps        = TAPS_POLY8_A;
                o_preset_mask = PRESET_DEG8;
            end
            SEL_LRC8: begin
                o_taps        = TAPS_LRC8;
                o_preset_mask = PRESET_DEG8;
            end
            SEL_CCITT:     o_taps = TAPS_CCITT;
            SEL_CCITT_REV: o_taps = TAPS_CCITT_REV;
        endcase
    end

endmodule // crc_poly_decode

// File: verilog/crc_gen_check.sv
`timescale 1ns/1ps
module crc_gen_check
    import crc_pkg::*;
(
    // clock and reset
    input  wire logic   i_ref_clk,
    input  wire logic   i_arst_n,
    // link to the controller
    crc_link_if.device  link,
    // observation
    output logic [15:0] o_remainder
);

    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic        cp_prev;
    logic        cp_fall;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic [15:0] taps;
    logic [15:0] preset_mask;
    logic        feedback;
    logic        fault;

    // pins except master reset pass two flops before use
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // idle pin levels: clock high, enable high, preset released, data low
            sync1 <= 8'he0;
            sync2 <= 8'he0;
        end else begin
            sync1 <= {link.cp, link.check_word_enable, link.preset_n, link.d,
                      1'b0, link.poly_select};
            sync2 <= sync1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cp_prev <= 1'b1;
        end else begin
            cp_prev <= sync2[7];
        end
    end

    assign cp_fall = cp_prev & ~sync2[7];

    crc_poly_decode u_decode (
        .i_poly_select (sync2[2:0]),
        .o_taps        (taps),
        .o_preset_mask (preset_mask)
    );

    // data only feeds the divider; nothing is driven into the message path
    assign feedback = sync2[4] ^ crc[15];

    always_comb begin
        if (sync2[6]) begin
            next_crc = {crc[14:0], 1'b0} ^ (feedback ? taps : 16'h0000);
        end else begin
            next_crc = {crc[14:0], 1'b0};
        end
    end

    // master reset clears straight away, not waiting for the clock
    always_ff @(posedge i_ref_clk or negedge i_arst_n or posedge link.master_reset) begin
        if (!i_arst_n || link.master_reset) begin
            crc <= 16'h0000;
        end else if (!sync2[5]) begin
            crc <= preset_mask;
        end else if (cp_fall) begin
            crc <= next_crc;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n or posedge link.master_reset) begin
        if (!i_arst_n || link.master_reset) begin
            fault <= 1'b0;
        end else if (!sync2[5]) begin
            fault <= |preset_mask;
        end else if (cp_fall) begin
            fault <= |next_crc;
        end
    end

    assign link.q          = crc[15];
    assign link.fault_flag = fault;
    assign o_remainder     = crc;

endmodule // crc_gen_check

// File: verilog/crc_link_ctrl.sv
//Function
//- three select bits pick one of eight
//- codes zero to three choose listed polynomials
//- codes four to seven choose listed polynomials
//- short polynomials right justified at output; code left-aligns them at the register top
//- data sampled on clock falling edge
//- data xor top bit drives taps
//- enable high for data, low for check
//- enable low shifts remainder without feedback
//- controller appends check bits by gating
//- checking feeds data and check, enable high
//- checker only monitors, never alters data
//- fault low on zero remainder, else high
//- fault holds until next edge or init
//- master reset clears register at once
//- preset sets top bits by degree
//- controller initializes before every computation (this controller initializes only when given a clear or preset command)
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module crc_link_ctrl
    import crc_pkg::*;
#(
    parameter int HALF_CYC = HALF_CYC_DEF,
    parameter int INIT_CYC = INIT_CYC_DEF
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // gated transmit stream
    output logic             o_tx_serial,
    // link to the generator/checker
    crc_link_if.host         link
);

    host_state_t state;
    logic [2:0]  ctrl_sel;
    logic [31:0] data_reg;
    logic [31:0] data_sh;
    logic [31:0] result;
    logic [1:0]  op;
    logic [5:0]  bits_left;
    logic [7:0]  timer;
    logic [1:0]  q_meta;
    logic [1:0]  q_sync;
    logic        cp_r;
    logic        d_r;
    logic        cwe_r;
    logic        preset_n_r;
    logic        mr_r;
    logic        tx_r;
    logic [31:0] rd_data;
    logic        addr_ok;
    logic        wr_en;
    logic        cmd_go;

    localparam logic [7:0] HALF_T = 8'(HALF_CYC - 1);
    localparam logic [7:0] INIT_T = 8'(INIT_CYC - 1);

    function automatic logic addr_mapped(input logic [11:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_DATA) || (a == ADDR_CMD) ||
               (a == ADDR_STATUS) || (a == ADDR_RESULT);
    endfunction

    assign addr_ok  = addr_mapped(i_paddr);
    assign o_pready = i_psel & i_penable;
    assign wr_en    = i_psel & i_penable & i_pwrite & addr_ok;
    assign cmd_go   = wr_en && (i_paddr == ADDR_CMD) && (state == ST_IDLE);

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (i_paddr)
            ADDR_CTRL:   rd_data = {29'h0, ctrl_sel};
            ADDR_DATA:   rd_data = data_reg;
            ADDR_CMD:    rd_data = {18'h0, bits_left, 6'h0, op};
            ADDR_STATUS: rd_data = {29'h0, q_sync[1], q_sync[0], state != ST_IDLE};
            ADDR_RESULT: rd_data = result;
            default:     rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_psel && !i_penable) begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_data;
            o_pslverr <= ~addr_ok;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_sel <= CTRL_RESET;
            data_reg <= 32'h0000_0000;
        end else if (wr_en && i_paddr == ADDR_CTRL && state == ST_IDLE) begin
            ctrl_sel <= i_pwdata[2:0];
        end else if (wr_en && i_paddr == ADDR_DATA && state == ST_IDLE) begin
            data_reg <= i_pwdata;
        end
    end

    // returning pins pass two flops
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q_meta <= 2'h0;
            q_sync <= 2'h0;
        end else begin
            q_meta <= {link.q, link.fault_flag};
            q_sync <= q_meta;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state      <= ST_IDLE;
            op         <= OP_CLEAR;
            bits_left  <= 6'h00;
            timer      <= 8'h00;
            data_sh    <= 32'h0000_0000;
            result     <= 32'h0000_0000;
            cp_r       <= 1'b1;
            d_r        <= 1'b0;
            cwe_r      <= 1'b1;
            preset_n_r <= 1'b1;
            mr_r       <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cmd_go) begin
                        op        <= i_pwdata[CMD_OP_LSB +: 2];
                        bits_left <= i_pwdata[CMD_CNT_LSB +: 6];
                        data_sh   <= data_reg;
                        unique case (i_pwdata[CMD_OP_LSB +: 2])
                            OP_CLEAR: begin
                                mr_r  <= 1'b1;
                                timer <= INIT_T;
                                state <= ST_INIT;
                            end
                            OP_PRESET: begin
                                preset_n_r <= 1'b0;
                                timer      <= INIT_T;
                                state      <= ST_INIT;
                            end
                            OP_DATA: begin
                                if (i_pwdata[CMD_CNT_LSB +: 6] != 6'h00) begin
                                    cwe_r <= 1'b1;
                                    d_r   <= data_reg[31];
                                    timer <= HALF_T;
                                    state <= ST_HIGH;
                                end
                            end
                            OP_CHECK: begin
                                if (i_pwdata[CMD_CNT_LSB +: 6] != 6'h00) begin
                                    result <= 32'h0000_0000;
                                    cwe_r  <= 1'b0;
                                    timer  <= HALF_T;
                                    state  <= ST_HIGH;
                                end
                            end
                        endcase
                    end
                end
                ST_INIT: begin
                    if (timer == 8'h00) begin
                        mr_r       <= 1'b0;
                        preset_n_r <= 1'b1;
                        state      <= ST_IDLE;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                ST_HIGH: begin
                    if (timer == 8'h00) begin
                        if (op == OP_CHECK) begin
                            result <= {result[30:0], q_sync[1]};
                        end
                        cp_r  <= 1'b0;
                        timer <= HALF_T;
                        state <= ST_LOW;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                ST_LOW: begin
                    if (timer == 8'h00) begin
                        cp_r      <= 1'b1;
                        data_sh   <= {data_sh[30:0], 1'b0};
                        bits_left <= bits_left - 6'h01;
                        if (bits_left == 6'h01) begin
                            cwe_r <= 1'b1;
                            d_r   <= 1'b0;
                            state <= ST_IDLE;
                        end else begin
                            d_r   <= data_sh[30];
                            timer <= HALF_T;
                            state <= ST_HIGH;
                        end
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
            endcase
        end
    end

    // check bits follow the data on the outgoing stream
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_r <= 1'b0;
        end else begin
            tx_r <= cwe_r ? d_r : q_sync[1];
        end
    end

    assign o_tx_serial            = tx_r;
    assign link.cp                = cp_r;
    assign link.d                 = d_r;
    assign link.check_word_enable = cwe_r;
    assign link.poly_select       = ctrl_sel;
    assign link.preset_n          = preset_n_r;
    assign link.master_reset      = mr_r;

endmodule // crc_link_ctrl

// File: test/crc_link_checker.sv
`timescale 1ns/1ps
module crc_link_checker
    import crc_pkg::*;
(
    // clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_arst_n,
    // link signals
    input wire logic        cp,
    input wire logic        d,
    input wire logic        check_word_enable,
    input wire logic [2:0]  poly_select,
    input wire logic        preset_n,
    input wire logic        master_reset,
    input wire logic        q,
    input wire logic        fault_flag,
    // device register
    input wire logic [15:0] o_remainder
);
    localparam logic [15:0] TAB [8] = '{TAPS_CRC16, TAPS_CRC16_REV, TAPS_POLY16_A,
        TAPS_CRC12, TAPS_POLY8_A, TAPS_LRC8, TAPS_CCITT, TAPS_CCITT_REV};

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    function automatic logic [15:0] step(logic [15:0] r, logic b, logic [2:0] s);
        return (r << 1) ^ ((b ^ r[15]) ? TAB[s] : 16'h0000);
    endfunction

    function automatic logic [15:0] mask(logic [2:0] s);
        return (s == SEL_CRC12) ? 16'hfff0 : (s[2:1] == 2'h2) ? 16'hff00 : 16'hffff;
    endfunction

    sequence s_preset_held;
        !preset_n [*4];
    endsequence

    sequence s_quiet;
        (cp && preset_n && !master_reset) [*6];
    endsequence

    AST_MR_CLEAR: assert property (master_reset && $past(master_reset)
        |-> o_remainder == 16'h0000 && !fault_flag) else $error("clear failed");
    AST_PRESET: assert property (s_preset_held
        |=> o_remainder == mask(poly_select) && fault_flag) else $error("preset failed");
    AST_INIT_LEN: assert property ($fell(preset_n) |-> s_preset_held ##1 preset_n)
        else $error("preset pulse length");
    AST_STEP: assert property ($changed(o_remainder) && $past(check_word_enable)
        && preset_n && !master_reset
        |-> o_remainder == step($past(o_remainder), $past(d), poly_select))
        else $error("feedback step wrong");
    AST_SHIFT_OUT: assert property ($changed(o_remainder) && !$past(check_word_enable)
        && preset_n && !master_reset |-> o_remainder == ($past(o_remainder) << 1))
        else $error("remainder shift wrong");
    AST_FALL_ONLY: assert property ($changed(o_remainder) && preset_n && !master_reset
        |-> !$past(cp)) else $error("update without clock fall");
    AST_FAULT: assert property ($stable(o_remainder) [*3]
        |-> fault_flag == (o_remainder != 16'h0000)) else $error("fault flag wrong");
    AST_HOLD: assert property (s_quiet |-> $stable(fault_flag))
        else $error("fault flag moved");
    AST_Q_TOP: assert property ($stable(o_remainder) |-> q == o_remainder[15])
        else $error("q is not register top");
    AST_CWE_CP: assert property ($changed(d) || $changed(check_word_enable) |-> cp)
        else $error("data changed while clock low");
endmodule // crc_link_checker

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import crc_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] remainder;
    logic        tx;
    logic        tx_q [$];
    logic [15:0] m_reg = 16'h0000;
    logic [2:0]  m_sel = 3'h0;
    logic [31:0] lfsr  = 32'hbbf3;
    int          mismatches  = 0;
    int          check_count = 0;
    logic [15:0] tap_tab [8] = '{TAPS_CRC16, TAPS_CRC16_REV, TAPS_POLY16_A, TAPS_CRC12,
        TAPS_POLY8_A, TAPS_LRC8, TAPS_CCITT, TAPS_CCITT_REV};
    int          deg_tab [8] = '{16, 16, 16, 12, 8, 8, 16, 16};

    crc_link_if link ();
    always #20 ref_clk = ~ref_clk;

    crc_link_ctrl i_crc_link_ctrl (
        .i_ref_clk   (ref_clk),
        .i_arst_n    (arst_n),
        .i_psel      (psel),
        .i_penable   (penable),
        .i_pwrite    (pwrite),
        .i_paddr     (paddr),
        .i_pwdata    (pwdata),
        .o_prdata    (prdata),
        .o_pready    (pready),
        .o_pslverr   (pslverr),
        .o_tx_serial (tx),
        .link        (link.host)
    );
    crc_gen_check i_crc_gen_check (
        .i_ref_clk   (ref_clk),
        .i_arst_n    (arst_n),
        .link        (link.device),
        .o_remainder (remainder)
    );
    crc_link_checker i_crc_link_checker (
        .i_ref_clk         (ref_clk),
        .i_arst_n          (arst_n),
        .cp                (link.cp),
        .d                 (link.d),
        .check_word_enable (link.check_word_enable),
        .poly_select       (link.poly_select),
        .preset_n          (link.preset_n),
        .master_reset      (link.master_reset),
        .q                 (link.q),
        .fault_flag        (link.fault_flag),
        .o_remainder       (remainder)
    );

    function automatic logic [31:0] next_rand(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rem(logic [15:0] exp);
        check_count++;
        if (remainder !== exp) begin
            mismatches++;
            $display("Error at %0t: remainder %h expected %h", $time, remainder, exp);
        end
    endtask

    task automatic chk_tx(logic exp);
        check_count++;
        if (tx !== exp) begin
            mismatches++;
            $display("Error at %0t: tx %h expected %h", $time, tx, exp);
        end
    endtask

    // each link clock fall puts one bit on the outgoing stream
    always begin : tx_mon
        logic exp;
        @(negedge link.cp);
        @(posedge ref_clk);
        exp = (tx_q.size() > 0) ? tx_q.pop_front() : 1'bx;
        chk_tx(exp);
    end

    // one apb transfer, held until pready is sampled high
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] v);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, v, r, e);
    endtask

    task automatic rd(logic [11:0] a, output logic [31:0] v);
        logic e;
        apb(1'b0, a, 32'h0, v, e);
    endtask

    task automatic op(logic [1:0] code, int cnt);
        logic [31:0] v;
        wr(ADDR_CMD, {18'h0, cnt[5:0], 6'h00, code});
        do rd(ADDR_STATUS, v); while (v[STAT_BUSY_BIT] !== 1'b0);
    endtask

    task automatic init(logic [1:0] code);
        op(code, 0);
        m_reg = (code == OP_CLEAR) ? 16'h0000 : 16'hffff << (16 - deg_tab[m_sel]);
    endtask

    // fault and synced q in status, plus the register itself
    task automatic chk_state();
        logic [31:0] v;
        rd(ADDR_STATUS, v);
        chk_reg(v & 32'h6, {29'h0, m_reg[15], m_reg != 16'h0000, 1'b0});
        chk_rem(m_reg);
        chk_reg(32'(tx_q.size()), 32'h0);
    endtask

    task automatic send(logic [31:0] w, int n);
        logic fb;
        for (int i = 0; i < n; i++) begin
            tx_q.push_back(w[31 - i]);
            fb = w[31 - i] ^ m_reg[15];
            m_reg = (m_reg << 1) ^ (fb ? tap_tab[m_sel] : 16'h0000);
        end
        wr(ADDR_DATA, w);
        op(OP_DATA, n);
    endtask

    task automatic gen_check(int n, output logic [31:0] res);
        logic [31:0] v;
        res = 32'h0;
        for (int i = 0; i < n; i++) begin
            res = {res[30:0], m_reg[15]};
            tx_q.push_back(m_reg[15]);
            m_reg = m_reg << 1;
        end
        op(OP_CHECK, n);
        rd(ADDR_RESULT, v);
        chk_reg(v & ((32'h1 << n) - 32'h1), res);
    endtask

    initial begin
        logic [31:0] v;
        logic [31:0] res;
        logic [31:0] w;
        logic        e;
        logic [1:0]  ini;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        chk_state();
        apb(1'b0, 12'h0fc, 32'h0, v, e);
        chk_reg({v[30:0], e}, 32'h1);
        for (int k = 0; k < 16; k++) begin
            m_sel = k[2:0];
            ini = k[3] ? OP_CLEAR : OP_PRESET;
            lfsr = next_rand(lfsr);
            wr(ADDR_CTRL, {29'h0, m_sel});
            init(ini);
            chk_state();
            send(lfsr, 16);
            chk_state();
            gen_check(deg_tab[m_sel], res);
            chk_state();
            w = {lfsr[31:16], 16'h0} | (res << (16 - deg_tab[m_sel]));
            for (int f = 0; f < 2; f++) begin
                init(ini);
                send(w ^ {f[0], 31'h0}, 16 + deg_tab[m_sel]);
                chk_state();
            end
        end
        give_verdict();
    end

    initial begin
        repeat (80000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end
endmodule // tb_top
